// file: design/ssmtf_pkg.sv
package ssmtf_pkg;

    // Core clock and link rate
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned LINK_BPS        = 10_000;
    localparam int unsigned HALF_BIT_CYCLES = CLK_HZ / (2 * LINK_BPS);

    localparam int unsigned BITS_PER_BYTE = 8;
    localparam int unsigned REG_ADDR_W    = 3;
    localparam int unsigned REG_DATA_W    = 8;

    // Register map of the master channel
    localparam logic [2:0] ADDR_CTRL     = 3'h0;
    localparam logic [2:0] ADDR_STATUS   = 3'h1;
    localparam logic [2:0] ADDR_TXDATA   = 3'h2;
    localparam logic [2:0] ADDR_RXDATA   = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;

    // Control register fields
    localparam int unsigned CTRL_TX_IRQ_EN  = 0;
    localparam int unsigned CTRL_RX_IRQ_EN  = 1;
    localparam int unsigned CTRL_TX_EN      = 2;
    localparam int unsigned CTRL_RX_EN      = 3;
    localparam int unsigned CTRL_PIN_SERIAL = 4;
    localparam int unsigned CTRL_GPIO_OUT   = 5;
    localparam int unsigned CTRL_GPIO_OE    = 6;
    localparam logic [7:0]  CTRL_WMASK      = 8'h7F;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // Status register fields
    localparam int unsigned STAT_TX_EMPTY = 0;
    localparam int unsigned STAT_RX_FULL  = 1;
    localparam int unsigned STAT_BUSY     = 2;
    localparam logic        TX_EMPTY_RESET = 1'b1;
    localparam logic        RX_FULL_RESET  = 1'b0;

    // Interrupt status and mask fields
    localparam int unsigned IRQ_TX   = 0;
    localparam int unsigned IRQ_RX   = 1;
    localparam int unsigned IRQ_W    = 2;
    localparam logic [1:0]  IRQ_STAT_RESET = 2'h0;
    localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;

    // Line levels
    localparam logic       LINE_IDLE = 1'b1;
    localparam logic [7:0] FILL_BYTE = 8'hFF;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LEAD = 2'b01,
        PH_LOW  = 2'b10
    } ssmtf_phase_e;

endpackage : ssmtf_pkg

// file: design/ssmtf_link_if.sv
interface ssmtf_link_if;
    logic sclk;
    logic masterTx;
    logic masterTxOe;
    logic slaveTx;
    logic slaveTxOe;
    logic masterRx;
    logic slaveRx;

    // Undriven data lines float high through the line pull-up
    assign slaveRx  = masterTxOe ? masterTx : 1'b1;
    assign masterRx = slaveTxOe ? slaveTx : 1'b1;

    modport master (
        output sclk,
        output masterTx,
        output masterTxOe,
        input  masterRx
    );

    modport slave (
        input  sclk,
        input  slaveRx,
        output slaveTx,
        output slaveTxOe
    );
endinterface : ssmtf_link_if

// file: design/ssmtf_sync.sv
module ssmtf_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pinIn,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
    } ssmtf_sync_s;

    ssmtf_sync_s s_reg;
    ssmtf_sync_s s_next;

    always_comb begin
        s_next        = s_reg;
        s_next.meta   = pinIn;
        s_next.stable = s_reg.meta;
        s_next.last   = s_reg.stable;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= '{meta: RESET_VAL, stable: RESET_VAL, last: RESET_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign level = s_reg.stable;
    assign rise  = s_reg.stable & ~s_reg.last;
    assign fall  = ~s_reg.stable & s_reg.last;
endmodule : ssmtf_sync

// file: design/ssmtf_slave.sv
module ssmtf_slave
    import ssmtf_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    ssmtf_link_if.slave     link,
    input  wire logic       enable,
    input  wire logic [7:0] txByte,
    input  wire logic       txWrite,
    output logic            txFree,
    output logic [7:0]      rxByte,
    output logic            rxValid
);
    typedef struct packed {
        logic [2:0] bitCnt;
        logic [7:0] txHolder;
        logic       holderFull;
        logic [7:0] txShift;
        logic [7:0] rxShift;
        logic [7:0] rxByte;
        logic       rxValid;
        logic       txd;
        logic       txdOe;
        logic       txFree;
    } ssmtf_slave_s;

    localparam ssmtf_slave_s S_RESET = '{
        bitCnt: 3'h0, txHolder: FILL_BYTE, holderFull: 1'b0, txShift: FILL_BYTE,
        rxShift: 8'h00, rxByte: 8'h00, rxValid: 1'b0, txd: LINE_IDLE,
        txdOe: 1'b0, txFree: 1'b1};

    ssmtf_slave_s s_reg;
    ssmtf_slave_s s_next;
    logic         clkLevel;
    logic         clkRise;
    logic         clkFall;
    logic         dataIn;

    ssmtf_sync #(.RESET_VAL(LINE_IDLE)) u_clk_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pinIn   (link.sclk),
        .level   (clkLevel),
        .rise    (clkRise),
        .fall    (clkFall)
    );

    ssmtf_sync #(.RESET_VAL(LINE_IDLE)) u_data_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pinIn   (link.slaveRx),
        .level   (dataIn),
        .rise    (),
        .fall    ()
    );

    always_comb begin
        s_next         = s_reg;
        s_next.rxValid = 1'b0;
        if (txWrite) begin
            s_next.txHolder   = txByte;
            s_next.holderFull = 1'b1;
        end
        // Reload only between bytes, while the clock rests high
        if (s_reg.bitCnt == 3'h0 && s_reg.holderFull && clkLevel && !clkFall) begin
            s_next.txShift    = s_reg.txHolder;
            s_next.holderFull = txWrite;
        end
        if (clkFall) begin
            s_next.txd = s_reg.txShift[0];
        end
        if (clkRise) begin
            s_next.rxShift = {dataIn, s_reg.rxShift[7:1]};
            s_next.txShift = {1'b1, s_reg.txShift[7:1]};
            s_next.bitCnt  = s_reg.bitCnt + 3'h1;
            if (s_reg.bitCnt == 3'(BITS_PER_BYTE - 1)) begin
                s_next.rxByte  = {dataIn, s_reg.rxShift[7:1]};
                s_next.rxValid = 1'b1;
                s_next.txShift = FILL_BYTE;
            end
        end
        if (!enable) begin
            s_next.bitCnt = 3'h0;
            s_next.txd    = LINE_IDLE;
        end
        s_next.txdOe  = enable;
        s_next.txFree = ~s_next.holderFull;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= S_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.slaveTx   = s_reg.txd;
    assign link.slaveTxOe = s_reg.txdOe;
    assign txFree         = s_reg.txFree;
    assign rxByte         = s_reg.rxByte;
    assign rxValid        = s_reg.rxValid;
endmodule : ssmtf_slave

// file: design/ssmtf_master.sv
module ssmtf_master
    import ssmtf_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = HALF_BIT_CYCLES
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [REG_ADDR_W-1:0] regAddr,
    input  wire logic [REG_DATA_W-1:0] regWdata,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic      [REG_DATA_W-1:0] regRdata,
    output logic                       irq,
    ssmtf_link_if.master               link
);
    localparam int unsigned CNT_W = $clog2(HALF_CYCLES) + 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYCLES - 1);

    typedef struct packed {
        logic [7:0]        ctrl;
        logic              txEmpty;
        logic              rxFull;
        logic [7:0]        txHolder;
        logic [7:0]        txShift;
        logic [7:0]        rxShift;
        logic [7:0]        rxBuf;
        logic [IRQ_W-1:0]  irqStat;
        logic [IRQ_W-1:0]  irqMask;
        ssmtf_phase_e      phase;
        logic [CNT_W-1:0]  halfCnt;
        logic [2:0]        bitCnt;
        logic              sclk;
        logic              txd;
        logic              txdOe;
        logic              irq;
        logic [7:0]        rdata;
    } ssmtf_master_s;

    localparam ssmtf_master_s S_RESET = '{
        ctrl: CTRL_RESET, txEmpty: TX_EMPTY_RESET, rxFull: RX_FULL_RESET,
        txHolder: 8'h00, txShift: FILL_BYTE, rxShift: 8'h00, rxBuf: 8'h00,
        irqStat: IRQ_STAT_RESET, irqMask: IRQ_MASK_RESET, phase: PH_IDLE,
        halfCnt: '0, bitCnt: 3'h0, sclk: LINE_IDLE, txd: LINE_IDLE,
        txdOe: 1'b0, irq: 1'b0, rdata: 8'h00};

    ssmtf_master_s s_reg;
    ssmtf_master_s s_next;
    logic          rxIn;

    ssmtf_sync #(.RESET_VAL(LINE_IDLE)) u_rx_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pinIn   (link.masterRx),
        .level   (rxIn),
        .rise    (),
        .fall    ()
    );

    always_comb begin
        logic       txEvent;
        logic       rxEvent;
        logic       txOn;
        logic       rxOn;
        logic [7:0] rdValue;
        logic [7:0] rxNew;

        s_next  = s_reg;
        txEvent = 1'b0;
        rxEvent = 1'b0;
        rdValue = 8'h00;
        rxNew   = {rxIn, s_reg.rxShift[7:1]};
        txOn    = s_reg.ctrl[CTRL_TX_EN];
        rxOn    = s_reg.ctrl[CTRL_RX_EN];

        // Software side; every hardware set below overrides these clears
        if (regWrite) begin
            unique case (regAddr)
                ADDR_CTRL: begin
                    s_next.ctrl = regWdata & CTRL_WMASK;
                end
                ADDR_STATUS: begin
                    if (!regWdata[STAT_TX_EMPTY]) begin
                        s_next.txEmpty = 1'b0;
                    end
                    if (!regWdata[STAT_RX_FULL]) begin
                        s_next.rxFull = 1'b0;
                    end
                end
                ADDR_TXDATA: begin
                    s_next.txHolder = regWdata;
                end
                ADDR_IRQ_STAT: begin
                    s_next.irqStat = s_reg.irqStat & ~regWdata[IRQ_W-1:0];
                end
                ADDR_IRQ_MASK: begin
                    s_next.irqMask = regWdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Each rising transmit enable, first start or restart, asks for a byte
        if (s_next.ctrl[CTRL_TX_EN] && !txOn) begin
            txEvent    = 1'b1;
            s_next.txd = LINE_IDLE;
        end

        unique case (s_reg.phase)
            PH_IDLE: begin
                if (txOn && !s_reg.txEmpty) begin
                    s_next.txShift = s_reg.txHolder;
                    s_next.txEmpty = 1'b1;
                    txEvent        = 1'b1;
                    s_next.txd     = s_reg.txHolder[0];
                    s_next.halfCnt = '0;
                    s_next.bitCnt  = 3'h0;
                    s_next.phase   = PH_LEAD;
                end else if (!txOn && rxOn && !s_reg.rxFull) begin
                    // Receive-only: clock a dummy byte while the buffer has room
                    s_next.txShift = FILL_BYTE;
                    s_next.halfCnt = '0;
                    s_next.bitCnt  = 3'h0;
                    s_next.phase   = PH_LEAD;
                end
            end
            PH_LEAD: begin
                s_next.halfCnt = s_reg.halfCnt + CNT_W'(1);
                if (s_reg.halfCnt == CNT_LAST) begin
                    s_next.halfCnt = '0;
                    s_next.sclk    = 1'b0;
                    s_next.txd     = s_reg.txShift[0];
                    s_next.phase   = PH_LOW;
                end
            end
            PH_LOW: begin
                s_next.halfCnt = s_reg.halfCnt + CNT_W'(1);
                if (s_reg.halfCnt == CNT_LAST) begin
                    // Data changes only at frame start or on the falling edge, so the slave's
                    // sample at the rise sees a settled line
                    s_next.halfCnt = '0;
                    s_next.sclk    = 1'b1;
                    s_next.rxShift = rxNew;
                    s_next.txShift = {1'b1, s_reg.txShift[7:1]};
                    s_next.bitCnt  = s_reg.bitCnt + 3'h1;
                    s_next.phase   = PH_LEAD;
                    if (s_reg.bitCnt == 3'(BITS_PER_BYTE - 1)) begin
                        s_next.phase  = PH_IDLE;
                        s_next.bitCnt = 3'h0;
                        // An unread buffer is kept; the new byte is dropped
                        if (rxOn && !s_reg.rxFull) begin
                            s_next.rxBuf  = rxNew;
                            s_next.rxFull = 1'b1;
                            rxEvent       = 1'b1;
                        end
                    end
                end
            end
        endcase

        if (!s_next.ctrl[CTRL_TX_EN] && !s_next.ctrl[CTRL_RX_EN]) begin
            s_next.phase   = PH_IDLE;
            s_next.sclk    = LINE_IDLE;
            s_next.halfCnt = '0;
            s_next.bitCnt  = 3'h0;
        end

        // Pin ownership
        if (s_next.ctrl[CTRL_TX_EN]) begin
            s_next.txdOe = 1'b1;
        end else if (s_next.ctrl[CTRL_PIN_SERIAL]) begin
            s_next.txdOe = 1'b0;
            s_next.txd   = LINE_IDLE;
        end else begin
            s_next.txdOe = s_next.ctrl[CTRL_GPIO_OE];
            s_next.txd   = s_next.ctrl[CTRL_GPIO_OUT];
        end

        // Pending bits gated by the interrupt enables
        if (txEvent && s_next.ctrl[CTRL_TX_IRQ_EN]) begin
            s_next.irqStat[IRQ_TX] = 1'b1;
        end
        if (rxEvent && s_next.ctrl[CTRL_RX_IRQ_EN]) begin
            s_next.irqStat[IRQ_RX] = 1'b1;
        end
        s_next.irq = |(s_next.irqStat & s_next.irqMask);

        if (regRead) begin
            unique case (regAddr)
                ADDR_CTRL: begin
                    rdValue = s_reg.ctrl;
                end
                ADDR_STATUS: begin
                    rdValue[STAT_TX_EMPTY] = s_reg.txEmpty;
                    rdValue[STAT_RX_FULL]  = s_reg.rxFull;
                    rdValue[STAT_BUSY]     = (s_reg.phase != PH_IDLE);
                end
                ADDR_TXDATA: begin
                    rdValue = s_reg.txHolder;
                end
                ADDR_RXDATA: begin
                    rdValue = s_reg.rxBuf;
                end
                ADDR_IRQ_STAT: begin
                    rdValue[IRQ_W-1:0] = s_reg.irqStat;
                end
                ADDR_IRQ_MASK: begin
                    rdValue[IRQ_W-1:0] = s_reg.irqMask;
                end
                default: begin
                    rdValue = 8'h00;
                end
            endcase
        end
        s_next.rdata = rdValue;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= S_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign regRdata        = s_reg.rdata;
    assign irq             = s_reg.irq;
    assign link.sclk       = s_reg.sclk;
    assign link.masterTx   = s_reg.txd;
    assign link.masterTxOe = s_reg.txdOe;
endmodule : ssmtf_master

// file: verif/ssmtf_link_asserts.sv
module ssmtf_link_asserts #(
    parameter int unsigned HALF_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic masterTx,
    input wire logic masterTxOe,
    input wire logic slaveTx,
    input wire logic slaveTxOe,
    input wire logic masterRx,
    input wire logic slaveRx
);
    timeunit 1ns;
    timeprecision 100ps;

    logic        sclkQ;
    logic [15:0] runLen;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Saturating length of the current clock level, so long idle spells never wrap
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclkQ  <= 1'b1;
            runLen <= 16'hFFFF;
        end else begin
            sclkQ <= sclk;
            if (sclk != sclkQ) begin
                runLen <= 16'h0000;
            end else if (runLen != 16'hFFFF) begin
                runLen <= runLen + 16'h0001;
            end
        end
    end

    a_low_phase: assert property ((sclk && !sclkQ) |-> runLen == 16'(HALF_CYCLES - 1))
        else $error("serial clock low phase has the wrong length");
    a_high_min: assert property ((!sclk && sclkQ) |-> runLen >= 16'(HALF_CYCLES - 1))
        else $error("serial clock high phase too short");
    a_low_max: assert property ((!sclk && !sclkQ) |-> runLen < 16'(HALF_CYCLES))
        else $error("serial clock held low too long");
    a_rise_high: assert property ((sclk && !sclkQ) |=> sclk [*3])
        else $error("serial clock fell right after rising");
    a_tx_hold_low: assert property (!sclkQ |-> $stable(masterTx))
        else $error("master data moved while clock low or at its rise");
    a_slave_hold: assert property ((sclk && !sclkQ) |-> $stable(slaveTx) [*4])
        else $error("slave data moved around the sampling edge");
    a_oe_hold_low: assert property (!sclk |-> $stable(masterTxOe))
        else $error("master pin enable moved inside a frame");
    a_reset_idle: assert property ($fell(rst) |-> sclk && masterTx && !masterTxOe)
        else $error("link not idle and floating after reset");

    c_frame_bit: cover property (sclk && !sclkQ);
    c_pin_float: cover property ($fell(masterTxOe));
    c_pin_drive: cover property ($rose(masterTxOe));
endmodule : ssmtf_link_asserts

// file: verif/ssmtf_tb_top.sv
module ssmtf_tb_top
    import ssmtf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // A short half period that still leaves the slave's synchronisers settled
    localparam int unsigned HALF = 8;

    logic       clk_sys;
    logic       rst;
    logic [2:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic       regWrite;
    logic       regRead;
    logic       irq;
    logic [7:0] txByte;
    logic       txWrite;
    logic       txFree;
    logic [7:0] rxByte;
    logic       rxValid;
    int         miscompares;
    int         n_tests;
    int         cycles;

    ssmtf_link_if link ();

    ssmtf_master #(.HALF_CYCLES(HALF)) i_ssmtf_master (
        .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .irq(irq), .link(link)
    );

    ssmtf_slave i_ssmtf_slave (
        .clk_sys(clk_sys), .rst(rst), .link(link), .enable(1'b1), .txByte(txByte),
        .txWrite(txWrite), .txFree(txFree), .rxByte(rxByte), .rxValid(rxValid)
    );

    ssmtf_link_asserts #(.HALF_CYCLES(HALF)) i_ssmtf_link_asserts (
        .clk_sys(clk_sys), .rst(rst), .sclk(link.sclk), .masterTx(link.masterTx),
        .masterTxOe(link.masterTxOe), .slaveTx(link.slaveTx), .slaveTxOe(link.slaveTxOe),
        .masterRx(link.masterRx), .slaveRx(link.slaveRx)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task summarize;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize

    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr

    task chkReg(input logic [2:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 chk(name, exp, regRdata);
    endtask : chkReg

    // Pin follows a control write on the same edge as the control register
    task chkPin(input logic [1:0] exp, input string name);
        repeat (2) @(posedge clk_sys);
        #1 chk(name, {6'h00, exp}, {6'h00, link.masterTxOe, link.masterTx});
    endtask : chkPin

    task waitRx;
        repeat (400) begin
            @(posedge clk_sys);
            #1;
            if (rxValid === 1'b1) break;
        end
        chk("slave byte seen", 8'h01, {7'h00, rxValid});
    endtask : waitRx

    // Slave holder is full for one cycle, then moves into its shifter
    task slaveLoad(input logic [7:0] b);
        @(posedge clk_sys);
        txWrite <= 1'b1;
        txByte  <= b;
        @(posedge clk_sys);
        txWrite <= 1'b0;
        #1 chk("slave holder taken", 8'h00, {7'h00, txFree});
        @(posedge clk_sys);
        #1 chk("slave holder moved", 8'h01, {7'h00, txFree});
    endtask : slaveLoad

    task t_reset;
        chkReg(ADDR_CTRL, 8'h00, "ctrl reset");
        chkReg(ADDR_STATUS, 8'h01, "status reset");
        chkReg(ADDR_IRQ_STAT, 8'h00, "irq status reset");
        chkReg(ADDR_IRQ_MASK, 8'h00, "irq mask reset");
        wr(3'h7, 8'hFF);
        chkReg(3'h7, 8'h00, "unmapped");
    endtask : t_reset

    task t_pin;
        wr(ADDR_CTRL, 8'h10);
        chkPin(2'b01, "pin serial disabled");
        wr(ADDR_CTRL, 8'h60);
        chkPin(2'b11, "pin gpio high");
        wr(ADDR_CTRL, 8'h40);
        chkPin(2'b10, "pin gpio low");
    endtask : t_pin

    task t_start;
        wr(ADDR_IRQ_MASK, 8'h03);
        wr(ADDR_CTRL, 8'h13);
        chkReg(ADDR_IRQ_STAT, 8'h00, "no request before enable");
        wr(ADDR_CTRL, 8'h1F);
        chkReg(ADDR_IRQ_STAT, 8'h01, "request on enable");
        chk("irq on enable", 8'h01, {7'h00, irq});
        wr(ADDR_IRQ_STAT, 8'h01);
        chkReg(ADDR_IRQ_STAT, 8'h00, "request cleared");
        chk("irq cleared", 8'h00, {7'h00, irq});
        slaveLoad(8'hA5);
        wr(ADDR_TXDATA, 8'h3C);
        wr(ADDR_STATUS, 8'h02);
        waitRx();
        chk("slave got byte", 8'h3C, rxByte);
        chkReg(ADDR_STATUS, 8'h03, "empty and full set");
        chkReg(ADDR_IRQ_STAT, 8'h03, "both requests");
        chkReg(ADDR_RXDATA, 8'hA5, "received byte");
    endtask : t_start

    task t_overrun;
        wr(ADDR_TXDATA, 8'h5A);
        wr(ADDR_IRQ_STAT, 8'h03);
        wr(ADDR_STATUS, 8'h02);
        waitRx();
        chk("slave got second", 8'h5A, rxByte);
        chkReg(ADDR_STATUS, 8'h03, "full kept");
        chkReg(ADDR_RXDATA, 8'hA5, "buffer kept");
        chkReg(ADDR_IRQ_STAT, 8'h01, "no receive request");
        wr(ADDR_STATUS, 8'h01);
        chkReg(ADDR_STATUS, 8'h01, "full cleared");
    endtask : t_overrun

    task t_final;
        logic [7:0] lowCnt;
        wr(ADDR_CTRL, 8'h1E);
        wr(ADDR_IRQ_STAT, 8'h03);
        wr(ADDR_TXDATA, 8'h11);
        wr(ADDR_STATUS, 8'h02);
        waitRx();
        chkReg(ADDR_IRQ_STAT, 8'h02, "no transmit request");
        chkReg(ADDR_RXDATA, 8'hFF, "idle slave fill");
        wr(ADDR_STATUS, 8'h01);
        wr(ADDR_CTRL, 8'h1C);
        wr(ADDR_CTRL, 8'h10);
        chkPin(2'b01, "pin floats when off");
        wr(ADDR_TXDATA, 8'h77);
        wr(ADDR_STATUS, 8'h02);
        lowCnt = 8'h00;
        repeat (200) begin
            @(posedge clk_sys);
            #1;
            if (link.sclk !== 1'b1) lowCnt++;
        end
        chk("clock low while off", 8'h00, lowCnt);
    endtask : t_final

    task t_restart;
        wr(ADDR_IRQ_STAT, 8'h03);
        wr(ADDR_CTRL, 8'h13);
        wr(ADDR_CTRL, 8'h1F);
        chkReg(ADDR_IRQ_STAT, 8'h01, "restart request");
        wr(ADDR_IRQ_MASK, 8'h02);
        chkReg(ADDR_IRQ_MASK, 8'h02, "mask");
        chk("masked irq low", 8'h00, {7'h00, irq});
        waitRx();
        chk("restart byte", 8'h77, rxByte);
        chkReg(ADDR_IRQ_STAT, 8'h03, "restart receive");
        chk("unmasked irq high", 8'h01, {7'h00, irq});
    endtask : t_restart

    // Receive-only frames run while the buffer has room; clearing both enables aborts one
    task t_rxonly;
        wr(ADDR_IRQ_STAT, 8'h03);
        slaveLoad(8'hC3);
        wr(ADDR_CTRL, 8'h1A);
        wr(ADDR_STATUS, 8'h01);
        waitRx();
        chk("slave sees idle line", 8'hFF, rxByte);
        chkReg(ADDR_STATUS, 8'h03, "receive-only full");
        chkReg(ADDR_RXDATA, 8'hC3, "receive-only byte");
        chkReg(ADDR_IRQ_STAT, 8'h02, "receive-only request");
        chk("receive irq high", 8'h01, {7'h00, irq});
        wr(ADDR_STATUS, 8'h01);
        chkReg(ADDR_STATUS, 8'h05, "frame busy");
        wr(ADDR_CTRL, 8'h10);
        chkReg(ADDR_STATUS, 8'h01, "frame aborted");
    endtask : t_rxonly

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        rst         = 1'b1;
        regAddr     = 3'h0;
        regWdata    = 8'h00;
        regWrite    = 1'b0;
        regRead     = 1'b0;
        txByte      = 8'h00;
        txWrite     = 1'b0;
        miscompares = 0;
        n_tests     = 0;
        cycles      = 0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_pin();
        t_start();
        t_overrun();
        t_final();
        t_restart();
        t_rxonly();
        summarize();
    end
endmodule : ssmtf_tb_top
